// ==== src/fpma_regs.svh ====
// Register offsets, field positions, reset values and encodings for the address generator
`ifndef FPMA_REGS_SVH
`define FPMA_REGS_SVH

// Byte addresses of the software registers
`define FPMA_CTRL_ADDR 32'h0000_0000
`define FPMA_STATUS_ADDR 32'h0000_0004
`define FPMA_COUNT_ADDR 32'h0000_0008
`define FPMA_LASTWB_ADDR 32'h0000_000C

// Control fields
`define FPMA_CTRL_EN_BIT 0
`define FPMA_CTRL_REJ_BIT 1
`define FPMA_CTRL_RESET 2'h1

// Status fields
`define FPMA_STAT_BUSY_BIT 0
`define FPMA_STAT_UNPRED_BIT 1
`define FPMA_STAT_UNDEF_BIT 2

// Instruction encoding
`define FPMA_CP_LS_OP 3'h6
`define FPMA_PUW_UNIDX 3'h2
`define FPMA_PUW_INC 3'h3
`define FPMA_PUW_DEC 3'h5
`define FPMA_PUW_UNDEF_A 3'h1
`define FPMA_PUW_UNDEF_B 3'h7
`define FPMA_COND_ALWAYS 4'hE
`define FPMA_PC_INDEX 4'hF
`define FPMA_CP_SINGLE 4'hA
`define FPMA_CP_DOUBLE 4'hB

// Offset limits and address step
`define FPMA_MIN_OFFSET 1
`define FPMA_MAX_OFFSET 33
`define FPMA_STEP 32'h0000_0004

// Bus encodings
`define FPMA_HTRANS_NONSEQ_BIT 1

`endif

// ==== src/fpma_pkg.sv ====
// Types shared by the address generator and its decoder
`default_nettype none
package fpma_pkg;
    typedef enum logic [1:0] {FPMA_MODE_NONE, FPMA_MODE_UNIDX, FPMA_MODE_INC, FPMA_MODE_DEC} fpma_mode_t;
    typedef enum logic [1:0] {FPMA_PREC_SINGLE, FPMA_PREC_DOUBLE, FPMA_PREC_UNKNOWN} fpma_prec_t;
    typedef enum logic [1:0] {FPMA_ST_IDLE, FPMA_ST_XFER, FPMA_ST_WB} fpma_state_t;
endpackage
`default_nettype wire

// ==== src/fpma_decode.sv ====
// Field decoder for floating-point load/store-multiple instructions
`default_nettype none
`include "fpma_regs.svh"
module fpma_decode #(
    parameter logic [3:0] CP_SINGLE = `FPMA_CP_SINGLE,
    parameter logic [3:0] CP_DOUBLE = `FPMA_CP_DOUBLE,
    parameter int MAX_OFFSET = `FPMA_MAX_OFFSET
) (
    // Instruction
    input wire logic [31:0] instr_word,
    // Decoded fields
    output fpma_pkg::fpma_mode_t mode,
    output fpma_pkg::fpma_prec_t prec,
    output logic claimed,
    output logic undef_mode,
    output logic unpredictable,
    output logic load_sel,
    output logic [3:0] base_register_index,
    output logic [3:0] first_fp_register,
    output logic [7:0] offset,
    output logic [7:0] words
);
    import fpma_pkg::*;

    initial begin
        if (CP_SINGLE == CP_DOUBLE || MAX_OFFSET < `FPMA_MIN_OFFSET || MAX_OFFSET > 255) begin
            $error("fpma_decode: bad parameters");
        end
    end

    wire logic [3:0] coprocessor_number_field = instr_word[11:8]; // [RULE4]
    wire logic [2:0] puw = {instr_word[24], instr_word[23], instr_word[21]};
    wire logic cp_space = instr_word[27:25] == `FPMA_CP_LS_OP; // [RULE4]
    wire logic cp_ours = coprocessor_number_field == CP_SINGLE || coprocessor_number_field == CP_DOUBLE;
    wire logic wb_form = puw == `FPMA_PUW_INC || puw == `FPMA_PUW_DEC;

    assign offset = instr_word[7:0]; // [RULE4]
    assign load_sel = instr_word[20]; // [RULE12]
    assign base_register_index = instr_word[19:16];
    assign first_fp_register = instr_word[15:12];
    // Without write-back the increment encoding falls back to unindexed
    assign mode = !cp_space ? FPMA_MODE_NONE :
                  puw == `FPMA_PUW_UNIDX ? FPMA_MODE_UNIDX : // [RULE3]
                  puw == `FPMA_PUW_INC ? FPMA_MODE_INC :
                  puw == `FPMA_PUW_DEC ? FPMA_MODE_DEC : FPMA_MODE_NONE; // [RULE4] [RULE11]
    assign undef_mode = cp_space && cp_ours && (puw == `FPMA_PUW_UNDEF_A || puw == `FPMA_PUW_UNDEF_B); // [RULE15]
    assign claimed = cp_ours && mode != FPMA_MODE_NONE; // [RULE15]
    // Precision comes from the coprocessor number plus offset bit 0
    assign prec = coprocessor_number_field == CP_SINGLE ? FPMA_PREC_SINGLE :
                  offset[0] ? FPMA_PREC_UNKNOWN : FPMA_PREC_DOUBLE; // [RULE13]
    // Unknown format reserves one word that is never moved
    assign words = prec == FPMA_PREC_UNKNOWN ? offset - 8'h01 : offset; // [RULE7] [RULE8] [RULE9]
    assign unpredictable = offset == 8'h00 || int'(offset) > MAX_OFFSET || // [RULE1]
                           (wb_form && base_register_index == `FPMA_PC_INDEX); // [RULE2]
endmodule
`default_nettype wire

// ==== src/fpma_addr_gen.sv ====
// Address generator for floating-point load/store-multiple instructions
`default_nettype none
`include "fpma_regs.svh"
// What this block does
// [RULE1] Length zero or above thirty-three is flagged unpredictable; optionally refused.
// [RULE2] Program counter as base in write-back forms is flagged unpredictable.
// [RULE3] Increment without write-back acts as unindexed, base left alone.
// [RULE4] Decrement form decoded from condition, opcode bits, base, register, coprocessor, length.
// [RULE5] Decrement form starts at base minus four times length.
// [RULE6] Every later address is the previous one plus four.
// [RULE7] Single precision moves one word per register; decrement ends at base minus four.
// [RULE8] Double precision moves length words; decrement ends at base minus four.
// [RULE9] Unknown format moves length minus one words; one reserved word skipped.
// [RULE10] Decrement with passing condition writes back base minus four times length.
// [RULE11] Decrement always writes back; no unchanged-base variant exists.
// [RULE12] Load-select bit picks load or store direction for the stream.
// [RULE13] Precision taken from coprocessor number together with length bit zero.
// [RULE14] Increment with write-back writes back base plus four times length.
// [RULE15] Undefined addressing encodings get no acknowledge from this block.
// [RULE16] Failed condition: no addresses and no base write-back.
module fpma_addr_gen #(
    parameter int MAX_OFFSET = `FPMA_MAX_OFFSET
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Instruction issue from the core
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] base_value,
    input wire logic cond_pass,
    output logic instr_ready,
    output logic instr_ack,
    // Memory address stream
    output logic mem_valid,
    output logic [31:0] mem_addr,
    output logic mem_load,
    output logic mem_last,
    input wire logic mem_ready,
    // Base write-back
    output logic wb_valid,
    output logic [3:0] wb_index,
    output logic [31:0] wb_value
);
    import fpma_pkg::*;

    initial begin
        if (MAX_OFFSET < `FPMA_MIN_OFFSET || MAX_OFFSET > 255) begin
            $error("fpma_addr_gen: MAX_OFFSET out of range");
        end
    end

    function automatic logic [31:0] scale4(input logic [7:0] off);
        scale4 = {22'h0, off, 2'b00};
    endfunction

    // Decode
    fpma_mode_t dec_mode;
    fpma_prec_t dec_prec;
    logic dec_claimed;
    logic dec_undef;
    logic dec_unpred;
    logic dec_load;
    logic [3:0] dec_base_idx;
    logic [7:0] dec_offset;
    logic [7:0] dec_words;

    fpma_decode #(
        .CP_SINGLE(`FPMA_CP_SINGLE),
        .CP_DOUBLE(`FPMA_CP_DOUBLE),
        .MAX_OFFSET(MAX_OFFSET)
    ) u_decode (
        .instr_word(instr_word),
        .mode(dec_mode),
        .prec(dec_prec),
        .claimed(dec_claimed),
        .undef_mode(dec_undef),
        .unpredictable(dec_unpred),
        .load_sel(dec_load),
        .base_register_index(dec_base_idx),
        .first_fp_register(),
        .offset(dec_offset),
        .words(dec_words)
    );

    // State
    fpma_state_t state_q;
    logic [1:0] ctrl_q;
    logic unpred_flag_q;
    logic undef_flag_q;
    logic [31:0] count_q;
    logic [31:0] base_q;
    logic [31:0] wbv_q;
    fpma_mode_t mode_q;
    fpma_prec_t prec_q;
    logic [7:0] off_q;
    logic [7:0] cnt_q;
    logic wb_en_q;
    logic instr_ready_q;
    logic instr_ack_q;
    logic mem_valid_q;
    logic [31:0] mem_addr_q;
    logic mem_load_q;
    logic mem_last_q;
    logic wb_valid_q;
    logic [3:0] wb_index_q;
    logic [31:0] wb_value_q;

    // Instruction take and its derived values
    wire logic take = instr_valid && instr_ready_q;
    wire logic always_condition = instr_word[31:28] == `FPMA_COND_ALWAYS;
    wire logic cond_ok = cond_pass || always_condition;
    wire logic refuse = ctrl_q[`FPMA_CTRL_REJ_BIT] && dec_unpred; // [RULE1] [RULE2]
    wire logic accept = take && dec_claimed && !refuse; // [RULE15]
    wire logic run = accept && cond_ok; // [RULE16]
    wire logic wb_form = dec_mode == FPMA_MODE_INC || dec_mode == FPMA_MODE_DEC; // [RULE3] [RULE11]
    wire logic [31:0] dec_span = scale4(dec_offset);
    wire logic [31:0] start_addr = dec_mode == FPMA_MODE_DEC ? base_value - dec_span : base_value; // [RULE5]
    wire logic [31:0] new_base = dec_mode == FPMA_MODE_DEC ? base_value - dec_span : // [RULE10]
                                 base_value + dec_span; // [RULE14]
    wire logic beat = mem_valid_q && mem_ready;
    wire logic en = ctrl_q[`FPMA_CTRL_EN_BIT];

    // Sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= FPMA_ST_IDLE;
            instr_ready_q <= 1'b0;
            instr_ack_q <= 1'b0;
            mem_valid_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_load_q <= 1'b0;
            mem_last_q <= 1'b0;
            wb_valid_q <= 1'b0;
            wb_index_q <= 4'h0;
            wb_value_q <= 32'h0000_0000;
            base_q <= 32'h0000_0000;
            wbv_q <= 32'h0000_0000;
            mode_q <= FPMA_MODE_NONE;
            prec_q <= FPMA_PREC_SINGLE;
            off_q <= 8'h00;
            cnt_q <= 8'h00;
            wb_en_q <= 1'b0;
        end else begin
            instr_ack_q <= accept; // [RULE15]
            case (state_q)
                FPMA_ST_IDLE: begin
                    instr_ready_q <= en && !take;
                    if (run) begin
                        base_q <= base_value;
                        wbv_q <= new_base;
                        mode_q <= dec_mode;
                        prec_q <= dec_prec;
                        off_q <= dec_offset;
                        wb_en_q <= wb_form;
                        wb_index_q <= dec_base_idx;
                        mem_load_q <= dec_load; // [RULE12]
                        if (dec_words != 8'h00) begin
                            mem_valid_q <= 1'b1;
                            mem_addr_q <= start_addr; // [RULE5]
                            mem_last_q <= dec_words == 8'h01;
                            cnt_q <= dec_words; // [RULE7] [RULE8] [RULE9]
                            state_q <= FPMA_ST_XFER;
                        end else if (wb_form) begin
                            wb_valid_q <= 1'b1;
                            wb_value_q <= new_base;
                            state_q <= FPMA_ST_WB;
                        end else begin
                            instr_ready_q <= en;
                        end
                    end else if (take) begin
                        // Refused, foreign or failed condition: nothing moves
                        instr_ready_q <= en; // [RULE16]
                    end
                end
                FPMA_ST_XFER: begin
                    if (beat) begin
                        if (mem_last_q) begin
                            mem_valid_q <= 1'b0;
                            mem_last_q <= 1'b0;
                            if (wb_en_q) begin
                                wb_valid_q <= 1'b1; // [RULE10] [RULE11] [RULE14]
                                wb_value_q <= wbv_q;
                                state_q <= FPMA_ST_WB;
                            end else begin
                                instr_ready_q <= en; // [RULE3]
                                state_q <= FPMA_ST_IDLE;
                            end
                        end else begin
                            mem_addr_q <= mem_addr_q + `FPMA_STEP; // [RULE6]
                            cnt_q <= cnt_q - 8'h01;
                            mem_last_q <= cnt_q == 8'h02;
                        end
                    end
                end
                FPMA_ST_WB: begin
                    wb_valid_q <= 1'b0;
                    instr_ready_q <= en;
                    state_q <= FPMA_ST_IDLE;
                end
                default: begin
                    state_q <= FPMA_ST_IDLE;
                end
            endcase
        end
    end

    // AHB-Lite slave, zero wait states
    logic ap_wr_q;
    logic [31:0] ap_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    wire logic ap_take = hsel && hready && htrans[`FPMA_HTRANS_NONSEQ_BIT];
    wire logic wr_ctrl = ap_wr_q && ap_addr_q == `FPMA_CTRL_ADDR;
    wire logic wr_stat = ap_wr_q && ap_addr_q == `FPMA_STATUS_ADDR;
    wire logic [31:0] status_word = {29'h0, undef_flag_q, unpred_flag_q, state_q != FPMA_ST_IDLE};
    wire logic [31:0] rd_mux = haddr == `FPMA_CTRL_ADDR ? {30'h0, ctrl_q} :
                               haddr == `FPMA_STATUS_ADDR ? status_word :
                               haddr == `FPMA_COUNT_ADDR ? count_q :
                               haddr == `FPMA_LASTWB_ADDR ? wb_value_q : 32'h0000_0000;
    wire logic unpred_set = take && dec_claimed && dec_unpred;
    wire logic undef_set = take && dec_undef;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 32'h0000_0000;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            ap_wr_q <= ap_take && hwrite;
            if (ap_take) begin
                ap_addr_q <= haddr;
            end
            hrdata_q <= (ap_take && !hwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software registers; hardware set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `FPMA_CTRL_RESET;
            unpred_flag_q <= 1'b0;
            undef_flag_q <= 1'b0;
            count_q <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= hwdata[1:0];
            end
            unpred_flag_q <= (unpred_flag_q && !(wr_stat && hwdata[`FPMA_STAT_UNPRED_BIT])) || unpred_set; // [RULE1]
            undef_flag_q <= (undef_flag_q && !(wr_stat && hwdata[`FPMA_STAT_UNDEF_BIT])) || undef_set;
            if (accept) begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    // Outputs
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign instr_ready = instr_ready_q;
    assign instr_ack = instr_ack_q;
    assign mem_valid = mem_valid_q;
    assign mem_addr = mem_addr_q;
    assign mem_load = mem_load_q;
    assign mem_last = mem_last_q;
    assign wb_valid = wb_valid_q;
    assign wb_index = wb_index_q;
    assign wb_value = wb_value_q;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_undef_no_ack: assert property (take && dec_undef |=> !instr_ack_q) // [RULE15]
        else $error("undefined encoding acknowledged");
    a_ack_claimed: assert property (accept |=> instr_ack_q) // [RULE15]
        else $error("claimed instruction not acknowledged");
    a_dec_start: assert property (run && dec_mode == FPMA_MODE_DEC && dec_words != 8'h00 // [RULE5]
        |=> mem_valid_q && mem_addr_q == base_q - scale4(off_q))
        else $error("decrement start address wrong");
    a_step_four: assert property (beat && !mem_last_q |=> mem_addr_q == $past(mem_addr_q) + `FPMA_STEP) // [RULE6]
        else $error("address step not four");
    a_dec_end: assert property (mem_valid_q && mem_last_q && mode_q == FPMA_MODE_DEC // [RULE7] [RULE8]
        && prec_q != FPMA_PREC_UNKNOWN |-> mem_addr_q == base_q - `FPMA_STEP)
        else $error("decrement end address wrong");
    a_unknown_end: assert property (mem_valid_q && mem_last_q && mode_q == FPMA_MODE_DEC // [RULE9]
        && prec_q == FPMA_PREC_UNKNOWN |-> mem_addr_q == base_q - 32'h0000_0008)
        else $error("unknown format end address wrong");
    a_dec_wb: assert property (beat && mem_last_q && mode_q == FPMA_MODE_DEC // [RULE10] [RULE11]
        |=> wb_valid_q && wb_value_q == base_q - scale4(off_q))
        else $error("decrement write-back wrong");
    a_inc_wb: assert property (wb_valid_q && mode_q == FPMA_MODE_INC // [RULE14]
        |-> wb_value_q == base_q + scale4(off_q))
        else $error("increment write-back wrong");
    a_unidx_quiet: assert property (wb_valid_q |-> mode_q != FPMA_MODE_UNIDX) // [RULE3]
        else $error("unindexed form wrote back");
    // One cycle only: a back-to-back instruction may legally start right after
    a_cond_quiet: assert property (take && !cond_ok // [RULE16]
        |=> !mem_valid_q && !wb_valid_q && state_q == FPMA_ST_IDLE)
        else $error("failed condition produced activity");
    a_unpred_flag: assert property (take && dec_claimed && dec_offset == 8'h00 |=> unpred_flag_q) // [RULE1]
        else $error("unpredictable length not flagged");
    a_load_dir: assert property (run |=> mem_load_q == $past(instr_word[20])) // [RULE12]
        else $error("load-select not carried");
    a_mem_hold: assert property (mem_valid_q && !mem_ready // [RULE6]
        |=> mem_valid_q && $stable(mem_addr_q))
        else $error("address dropped under stall");
    a_inc_start: assert property (run && dec_mode != FPMA_MODE_DEC && dec_words != 8'h00 // [RULE3]
        |=> mem_valid_q && mem_addr_q == base_q)
        else $error("increment start address wrong");
    a_unpred_pc: assert property (take && dec_claimed && wb_form && dec_base_idx == `FPMA_PC_INDEX // [RULE2]
        |=> unpred_flag_q)
        else $error("program counter base not flagged");
    a_refuse_quiet: assert property (take && refuse |=> !instr_ack_q && !mem_valid_q && !wb_valid_q) // [RULE1]
        else $error("refused instruction produced activity");
    a_undef_flag: assert property (take && dec_undef |=> undef_flag_q) // [RULE15]
        else $error("undefined encoding not flagged");

    // Beat tally, independent of the down-counter that ends the stream
    logic [7:0] beats_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            beats_q <= 8'h00;
        end else if (run) begin
            beats_q <= 8'h00;
        end else if (beat) begin
            beats_q <= beats_q + 8'h01;
        end
    end
    a_word_count: assert property (beat && mem_last_q // [RULE7] [RULE8] [RULE9]
        |-> beats_q + 8'h01 == (prec_q == FPMA_PREC_UNKNOWN ? off_q - 8'h01 : off_q))
        else $error("word count wrong");
endmodule
`default_nettype wire

// ==== testbench/fpma_mem_model.sv ====
// Memory-side partner that takes transfer addresses and logs them
`default_nettype none
module fpma_mem_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Stall control
    input wire logic slow,
    // Address stream
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    input wire logic mem_load,
    input wire logic mem_last,
    output logic mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [33:0] got_q[$];
    logic ready_q;
    assign mem_ready = ready_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b0;
        end else begin
            if (mem_valid && ready_q) begin
                got_q.push_back({mem_load, mem_last, mem_addr});
            end
            // Every other cycle when slow, so the block must hold its address
            ready_q <= slow ? ~ready_q : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fp_multi_transfer_addr_gen_tb.sv ====
// Self-checking bench for the load/store-multiple address generator
`default_nettype none
`include "fpma_regs.svh"
module fp_multi_transfer_addr_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, slow, instr_valid, cond_pass;
    logic [31:0] haddr, hwdata, instr_word, base_value, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic [31:0] hrdata, mem_addr, wb_value;
    wire logic [3:0] wb_index;
    wire logic hreadyout, hresp, instr_ready, instr_ack, mem_valid, mem_load, mem_last, mem_ready, wb_valid;
    int mismatches = 0;
    int cmp_count = 0;
    logic [3:0] cps[5] = '{4'hA, 4'hA, 4'hB, 4'hB, 4'hA};
    logic [7:0] offs[5] = '{8'h02, 8'h21, 8'h04, 8'h05, 8'h01};

    fpma_addr_gen dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word),
        .base_value(base_value), .cond_pass(cond_pass), .instr_ready(instr_ready), .instr_ack(instr_ack),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_load(mem_load), .mem_last(mem_last),
        .mem_ready(mem_ready), .wb_valid(wb_valid), .wb_index(wb_index), .wb_value(wb_value));
    fpma_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_valid(mem_valid),
        .mem_addr(mem_addr), .mem_load(mem_load), .mem_last(mem_last), .mem_ready(mem_ready));

    always #4 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [31:0] mk(logic [3:0] c, logic [2:0] puw, logic l, logic [3:0] rn, logic [3:0] cp,
        logic [7:0] off);
        return {c, 3'h6, puw[2], puw[1], 1'b0, puw[0], l, rn, 4'h2, cp, off};
    endfunction

    // One instruction from issue until the block is ready again
    task automatic run(input logic [3:0] c, input logic [2:0] puw, input logic l, input logic [3:0] rn,
        input logic [3:0] cp, input logic [7:0] off, input logic [31:0] base, input logic cpass, input logic xack);
        int acks, wbs, words, n;
        logic [31:0] wbv, wbi, start, xwb;
        logic pass;
        mem_u.got_q.delete();
        @(posedge hclk);
        instr_word <= mk(c, puw, l, rn, cp, off);
        base_value <= base;
        cond_pass <= cpass;
        instr_valid <= 1'b1;
        do @(posedge hclk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        acks = 0;
        wbs = 0;
        wbv = 0;
        wbi = 0;
        // Start at the take edge itself: the acknowledge stands for one cycle only
        for (n = 0; n < 300; n++) begin
            #1;
            if (instr_ack === 1'b1) acks++;
            if (wb_valid === 1'b1) begin
                wbs++;
                wbv = wb_value;
                wbi = {28'h0, wb_index};
            end
            if (instr_ready === 1'b1) break;
            @(posedge hclk);
        end
        pass = xack && (c == `FPMA_COND_ALWAYS || cpass);
        words = !pass ? 0 : (cp == `FPMA_CP_DOUBLE && off[0]) ? int'(off) - 1 : int'(off);
        start = (puw == `FPMA_PUW_DEC) ? base - {22'h0, off, 2'h0} : base;
        xwb = (puw == `FPMA_PUW_DEC) ? start : base + {22'h0, off, 2'h0};
        chk(32'(acks), {31'h0, xack});
        chk(32'(mem_u.got_q.size()), 32'(words));
        for (n = 0; n < words && n < mem_u.got_q.size(); n++) begin
            chk(mem_u.got_q[n][31:0], start + 32'(4 * n));
            chk(32'(mem_u.got_q[n][33:32]), {30'h0, l, n == words - 1});
        end
        chk(32'(wbs), {31'h0, pass && puw != `FPMA_PUW_UNIDX});
        if (wbs == 1) begin
            chk(wbv, xwb);
            chk(wbi, {28'h0, rn});
        end
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        $display("Error at %0t: watchdog expired got %h expected %h", $time, 32'h0, 32'h1);
        end_sim();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        instr_valid = 1'b0;
        instr_word = 32'h0;
        base_value = 32'h0;
        cond_pass = 1'b0;
        slow = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(`FPMA_CTRL_ADDR, 1'b0, 32'h0, v);
        chk(v, 32'h1);
        ahb(`FPMA_COUNT_ADDR, 1'b0, 32'h0, v);
        chk(v, 32'h0);
        ahb(32'h0000_0040, 1'b0, 32'h0, v);
        chk(v, 32'h0);
        ahb(`FPMA_CTRL_ADDR, 1'b1, 32'h3, v);
        ahb(`FPMA_CTRL_ADDR, 1'b0, 32'h0, v);
        chk(v, 32'h3);
        ahb(`FPMA_CTRL_ADDR, 1'b1, 32'h1, v);
        $display("Test registers done");
        // Condition field always runs even when the core's result is false
        for (int i = 0; i < 5; i++) begin
            slow <= i[0];
            run(`FPMA_COND_ALWAYS, `FPMA_PUW_DEC, i[0], 4'(i + 3), cps[i], offs[i],
                32'h8000_0100, 1'b0, 1'b1);
        end
        // Last decrement was one single word from 0x8000_0100
        ahb(`FPMA_LASTWB_ADDR, 1'b0, 32'h0, v);
        chk(v, 32'h8000_00FC);
        $display("Test decrement done");
        run(4'h1, `FPMA_PUW_INC, 1'b0, 4'h5, 4'hA, 8'h03, 32'h0000_2000, 1'b1, 1'b1);
        run(4'h1, `FPMA_PUW_UNIDX, 1'b1, 4'h6, 4'hB, 8'h04, 32'h0000_3000, 1'b1, 1'b1);
        run(4'h1, `FPMA_PUW_INC, 1'b1, 4'h7, 4'hB, 8'h03, 32'hFFFF_FFF0, 1'b1, 1'b1);
        $display("Test increment done");
        run(4'h0, `FPMA_PUW_DEC, 1'b1, 4'h2, 4'hA, 8'h04, 32'h0000_4000, 1'b0, 1'b1);
        run(4'h0, `FPMA_PUW_INC, 1'b0, 4'h2, 4'hB, 8'h02, 32'h0000_4000, 1'b0, 1'b1);
        $display("Test condition done");
        run(`FPMA_COND_ALWAYS, `FPMA_PUW_UNDEF_A, 1'b0, 4'h1, 4'hA, 8'h02, 32'h0000_5000, 1'b1, 1'b0);
        run(`FPMA_COND_ALWAYS, `FPMA_PUW_UNDEF_B, 1'b1, 4'h1, 4'hA, 8'h02, 32'h0000_5000, 1'b1, 1'b0);
        // Undefined flag up, busy low
        ahb(`FPMA_STATUS_ADDR, 1'b0, 32'h0, v);
        chk(v & 32'h5, 32'h4);
        $display("Test undefined done");
        ahb(`FPMA_CTRL_ADDR, 1'b1, 32'h3, v);
        ahb(`FPMA_STATUS_ADDR, 1'b1, 32'h6, v);
        ahb(`FPMA_STATUS_ADDR, 1'b0, 32'h0, v);
        chk(v & 32'h2, 32'h0);
        run(`FPMA_COND_ALWAYS, `FPMA_PUW_DEC, 1'b0, `FPMA_PC_INDEX, 4'hA, 8'h02, 32'h0000_6000, 1'b1, 1'b0);
        ahb(`FPMA_STATUS_ADDR, 1'b0, 32'h0, v);
        chk(v & 32'h2, 32'h2);
        ahb(`FPMA_STATUS_ADDR, 1'b1, 32'h6, v);
        run(`FPMA_COND_ALWAYS, `FPMA_PUW_INC, 1'b0, 4'h4, 4'hA, 8'h00, 32'h0000_6000, 1'b1, 1'b0);
        ahb(`FPMA_STATUS_ADDR, 1'b0, 32'h0, v);
        chk(v & 32'h2, 32'h2);
        ahb(`FPMA_STATUS_ADDR, 1'b1, 32'h6, v);
        run(`FPMA_COND_ALWAYS, `FPMA_PUW_INC, 1'b0, 4'h4, 4'hA, 8'h22, 32'h0000_6000, 1'b1, 1'b0);
        ahb(`FPMA_STATUS_ADDR, 1'b0, 32'h0, v);
        chk(v & 32'h2, 32'h2);
        ahb(`FPMA_CTRL_ADDR, 1'b1, 32'h1, v);
        // Ten claimed instructions were taken; refused and undefined ones do not count
        ahb(`FPMA_COUNT_ADDR, 1'b0, 32'h0, v);
        chk(v, 32'h0000_000A);
        $display("Test unpredictable done");
        end_sim();
    end
endmodule
`default_nettype wire
